/* File: dcf_data_config.sv */
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module dcf_data_config (
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    input  wire dcf_pkg::dcf_ahb_in_t  ahb_i,
    output      dcf_pkg::dcf_ahb_out_t ahb_o,
    input  wire logic [1:0]            loopback_code,
    input  wire logic                  rx_active,
    input  wire logic [3:0]            fifo_level,
    input  wire dcf_pkg::dcf_dma_in_t  dma_i,
    output      dcf_pkg::dcf_dma_out_t dma_o,
    output      logic                  word_mode,
    output      logic                  long_addr,
    output      logic                  send_enable,
    output      logic [1:0]            loop_mode,
    output      logic                  loop_active,
    output      logic [3:0]            fifo_thr_count,
    output      logic                  fifo_bus_req
);
    import dcf_pkg::*;

    dcf_state_t  s_r;
    dcf_state_t  s_nxt;
    logic        take;
    logic [31:0] status;

    localparam dcf_state_t DCF_STATE_RST = '{
        phase:       DCF_PH_IDLE,
        hit_cfg:     1'b0,
        hit_stat:    1'b0,
        ready:       1'b1,
        rdata:       32'h0000_0000,
        cfg:         DCF_CFG_RST,
        loop_mode:   DCF_LOOP_NORMAL,
        loop_active: 1'b0,
        thr:         4'h0,
        req:         1'b0
    };

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // Status word built from the live state
    always_comb
    begin
        status = '0;
        status[DCF_ST_WORD] = s_r.cfg.word_transfer_select;
        status[DCF_ST_SWAP] = s_r.cfg.word_transfer_select & s_r.cfg.byte_order_select;
        status[DCF_ST_LONG] = s_r.cfg.long_address_select;
        status[DCF_ST_SEND] = s_r.cfg.auto_init_remote;
        status[DCF_ST_LOOP +: 2] = s_r.loop_mode;
        status[DCF_ST_LPACT] = s_r.loop_active;
        status[DCF_ST_THR +: 4] = s_r.thr;
        status[DCF_ST_REQ] = s_r.req;
    end

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.ready = 1'b1;
        take = ahb_i.hsel & ahb_i.htrans[1] & ahb_i.hready;

        // Data phase of the previous transfer
        unique case (s_r.phase)
            DCF_PH_IDLE:
            begin
            end
            DCF_PH_WR:
            begin
                if (s_r.hit_cfg)
                    s_nxt.cfg = ahb_i.hwdata[DCF_CFG_W-1:0];
            end
            DCF_PH_RD:
            begin
            end
        endcase

        // Address phase, zero wait states
        s_nxt.rdata = '0;
        if (take)
        begin
            s_nxt.phase = ahb_i.hwrite ? DCF_PH_WR : DCF_PH_RD;
            s_nxt.hit_cfg = (ahb_i.haddr == DCF_ADDR_DATA_CONFIG);
            s_nxt.hit_stat = (ahb_i.haddr == DCF_ADDR_STATUS);
            if (!ahb_i.hwrite && (ahb_i.haddr == DCF_ADDR_STATUS))
                s_nxt.rdata = status;
        end
        else
        begin
            s_nxt.phase = DCF_PH_IDLE;
            s_nxt.hit_cfg = 1'b0;
            s_nxt.hit_stat = 1'b0;
        end

        if (s_r.cfg.loopback_select)
        begin
            s_nxt.loop_mode = DCF_LOOP_NORMAL;
            s_nxt.loop_active = 1'b0;
        end
        else
        begin
            s_nxt.loop_mode = loopback_code;
            s_nxt.loop_active = (loopback_code != DCF_LOOP_NORMAL);
        end

        s_nxt.thr = dcf_thr_count(s_r.cfg.fifo_threshold, s_r.cfg.word_transfer_select);
        s_nxt.req = rx_active &&
            (fifo_level >= dcf_thr_count(s_r.cfg.fifo_threshold, s_r.cfg.word_transfer_select));
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            s_r <= DCF_STATE_RST;
        else
            s_r <= s_nxt;
    end

    dcf_lanes u_lanes (
        .hclk    (hclk),
        .hresetn (hresetn),
        .cfg     (s_r.cfg),
        .dma_i   (dma_i),
        .dma_o   (dma_o)
    );

    assign ahb_o.hrdata    = s_r.rdata;
    assign ahb_o.hreadyout = s_r.ready;
    assign ahb_o.hresp     = 1'b0;
    assign word_mode       = s_r.cfg.word_transfer_select;
    assign long_addr       = s_r.cfg.long_address_select;
    assign send_enable     = s_r.cfg.auto_init_remote;
    assign loop_mode       = s_r.loop_mode;
    assign loop_active     = s_r.loop_active;
    assign fifo_thr_count  = s_r.thr;
    assign fifo_bus_req    = s_r.req;

    a_las_reset: assert property ($rose(hresetn) |-> long_addr && !word_mode && !send_enable)
        else $error("config not at power-up value");
    a_cfg_store: assert property (
        (s_r.phase == DCF_PH_WR && s_r.hit_cfg)
        |=> word_mode == $past(ahb_i.hwdata[0]) && long_addr == $past(ahb_i.hwdata[2]))
        else $error("config write not stored");
    a_send_follow: assert property (
        (s_r.phase == DCF_PH_WR && s_r.hit_cfg)
        |=> send_enable == $past(ahb_i.hwdata[4]) && s_r.cfg == $past(ahb_i.hwdata[6:0]))
        else $error("send enable not taken from write");
    a_cfg_hold: assert property (
        !(s_r.phase == DCF_PH_WR && s_r.hit_cfg) |=> $stable(s_r.cfg))
        else $error("config changed without a config write");
    a_write_only: assert property (
        (s_r.phase == DCF_PH_RD && s_r.hit_cfg) |-> ahb_o.hrdata == 32'h0000_0000)
        else $error("config register readable");
    a_rdata_idle: assert property (
        s_r.phase != DCF_PH_RD |-> ahb_o.hrdata == 32'h0000_0000)
        else $error("read data outside a read data phase");
    a_unmapped_read: assert property (
        (s_r.phase == DCF_PH_RD && !s_r.hit_cfg && !s_r.hit_stat) |-> ahb_o.hrdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_status_read: assert property (
        (s_r.phase == DCF_PH_RD && s_r.hit_stat) |-> ahb_o.hrdata == $past(status))
        else $error("status read does not match state");
    a_loop_forced: assert property (
        s_r.cfg.loopback_select |=> loop_mode == DCF_LOOP_NORMAL && !loop_active)
        else $error("loopback while select high");
    a_loop_code: assert property (!s_r.cfg.loopback_select |=> loop_mode == $past(loopback_code))
        else $error("loopback code not passed");
    a_loop_kind: assert property (
        !s_r.cfg.loopback_select |=> loop_active == ($past(loopback_code) != 2'h0))
        else $error("loopback active flag wrong");
    a_thr_byte0: assert property (
        (!s_r.cfg.word_transfer_select && s_r.cfg.fifo_threshold == 2'h0) |=> fifo_thr_count == 4'h2)
        else $error("byte threshold 0 not 2");
    a_thr_byte1: assert property (
        (!s_r.cfg.word_transfer_select && s_r.cfg.fifo_threshold == 2'h1) |=> fifo_thr_count == 4'h4)
        else $error("byte threshold 1 not 4");
    a_thr_byte2: assert property (
        (!s_r.cfg.word_transfer_select && s_r.cfg.fifo_threshold == 2'h2) |=> fifo_thr_count == 4'h8)
        else $error("byte threshold 2 not 8");
    a_thr_table: assert property (
        (!s_r.cfg.word_transfer_select && s_r.cfg.fifo_threshold == 2'h3) |=> fifo_thr_count == 4'hc)
        else $error("byte threshold 3 not 12");
    a_thr_word0: assert property (
        (s_r.cfg.word_transfer_select && s_r.cfg.fifo_threshold == 2'h0) |=> fifo_thr_count == 4'h1)
        else $error("word threshold 0 not 1");
    a_thr_word1: assert property (
        (s_r.cfg.word_transfer_select && s_r.cfg.fifo_threshold == 2'h1) |=> fifo_thr_count == 4'h2)
        else $error("word threshold 1 not 2");
    a_thr_word2: assert property (
        (s_r.cfg.word_transfer_select && s_r.cfg.fifo_threshold == 2'h2) |=> fifo_thr_count == 4'h4)
        else $error("word threshold 2 not 4");
    a_thr_word: assert property (
        (s_r.cfg.word_transfer_select && s_r.cfg.fifo_threshold == 2'h3) |=> fifo_thr_count == 4'h6)
        else $error("word threshold 3 not 6");
    a_fifo_req: assert property (
        ##1 fifo_bus_req == ($past(rx_active) && $past(fifo_level) >= dcf_thr_count(
        $past(s_r.cfg.fifo_threshold), $past(s_r.cfg.word_transfer_select))))
        else $error("bus request not at threshold");
    a_req_idle: assert property (!rx_active |=> !fifo_bus_req)
        else $error("bus request outside reception");
    a_zero_wait: assert property (ahb_o.hreadyout && !ahb_o.hresp)
        else $error("slave not ready or not okay");

endmodule : dcf_data_config

/* File: dcf_data_config_tb.sv */
`timescale 1ns/10ps
module dcf_data_config_tb;
    import dcf_pkg::*;

    logic          hclk = 1'b0;
    logic          hresetn;
    logic          hsel;
    logic [31:0]   haddr;
    logic [1:0]    htrans;
    logic          hwrite;
    logic [31:0]   hwdata;
    logic [31:0]   rd;
    logic [1:0]    lb;
    logic          rx;
    logic [3:0]    lvl;
    logic [3:0]    thr;
    dcf_dma_in_t   dcmd;
    dcf_ahb_in_t   ahb_i;
    dcf_ahb_out_t  ahb_o;
    logic [1:0]    loopback_code;
    logic          rx_active;
    logic [3:0]    fifo_level;
    dcf_dma_in_t   dma_i;
    dcf_dma_out_t  dma_o;
    logic          word_mode;
    logic          long_addr;
    logic          send_enable;
    logic [1:0]    loop_mode;
    logic          loop_active;
    logic [3:0]    fifo_thr_count;
    logic          fifo_bus_req;
    int            err_total;
    int            num_checks;
    logic [3:0]    tw [4] = '{4'h1, 4'h2, 4'h4, 4'h6};
    logic [3:0]    tb [4] = '{4'h2, 4'h4, 4'h8, 4'hc};

    always #5 hclk = ~hclk;
    assign ahb_i = {hsel, haddr, htrans, hwrite, 3'h2, hwdata, ahb_o.hreadyout};

    dcf_far_model far (.hclk(hclk), .hresetn(hresetn), .lb_cmd(lb), .rx_cmd(rx), .lvl_cmd(lvl),
        .dma_cmd(dcmd), .loopback_code(loopback_code), .rx_active(rx_active),
        .fifo_level(fifo_level), .dma_i(dma_i));

    dcf_data_config dut (.hclk(hclk), .hresetn(hresetn), .ahb_i(ahb_i), .ahb_o(ahb_o),
        .loopback_code(loopback_code), .rx_active(rx_active), .fifo_level(fifo_level),
        .dma_i(dma_i), .dma_o(dma_o), .word_mode(word_mode), .long_addr(long_addr),
        .send_enable(send_enable), .loop_mode(loop_mode), .loop_active(loop_active),
        .fifo_thr_count(fifo_thr_count), .fifo_bus_req(fifo_bus_req));

    task summarize;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : summarize

    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] d);
        int n;
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (ahb_o.hreadyout !== 1'b1 && n < 50);
        if (n >= 50)
            chk("hready_wait", 32'h0000_0001, 32'h0000_0000);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= wd;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (ahb_o.hreadyout !== 1'b1 && n < 50);
        d = ahb_o.hrdata;
        chk("hresp_okay", 32'h0, ahb_o.hresp);
        if (n >= 50)
            chk("hready_wait", 32'h0000_0001, 32'h0000_0000);
    endtask : ahb

    task settle;
        repeat (3) @(posedge hclk);
        #1;
    endtask : settle

    task cfg_wr(input logic [7:0] v);
        ahb(1'b1, DCF_ADDR_DATA_CONFIG, {24'h0000_00, v}, rd);
        settle();
    endtask : cfg_wr

    task far_set(input logic [1:0] l, input logic r, input logic [3:0] f);
        @(posedge hclk);
        lb  <= l;
        rx  <= r;
        lvl <= f;
        settle();
    endtask : far_set

    initial
    begin
        hresetn = 1'b0;
        {hsel, haddr, htrans, hwrite, hwdata, lb, rx, lvl} = '0;
        dcmd = '{16'hbeef, 16'h0003, 16'h1234};
        err_total = 0;
        num_checks = 0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        settle();
        chk("long_addr_rst", 32'h1, long_addr);
        // Config is written before any remote count
        // No auto-init send while bytes are swapped
        cfg_wr(8'h6f);
        chk("long_addr_set", 32'h1, long_addr);
        ahb(1'b0, DCF_ADDR_DATA_CONFIG, '0, rd);
        chk("cfg_read", 32'h0, rd);
        ahb(1'b0, 32'h0000_0100, '0, rd);
        chk("unmapped_read", 32'h0, rd);
        for (int w = 0; w < 2; w++)
            for (int c = 0; c < 4; c++)
            begin
                thr = w ? tw[c] : tb[c];
                cfg_wr({1'b0, c[1:0], 2'h1, 2'h0, w[0]});
                chk("word_mode", w, word_mode);
                chk("thr_count", thr, fifo_thr_count);
                ahb(1'b0, DCF_ADDR_STATUS, '0, rd);
                chk("status_thr", thr, rd[11:8]);
                far_set(2'h0, 1'b1, thr - 4'h1);
                chk("req_below", 32'h0, fifo_bus_req);
                far_set(2'h0, 1'b1, thr);
                chk("req_at", 32'h1, fifo_bus_req);
                far_set(2'h0, 1'b0, 4'h0);
                chk("req_idle", 32'h0, fifo_bus_req);
            end
        cfg_wr(8'h0f);
        chk("swap_data", 32'h3412, dma_o.data);
        chk("word_addr", 32'h0002, dma_o.addr);
        chk("upper_long", 32'hbeef, dma_o.upper);
        cfg_wr(8'h0a);
        chk("byte_data", 32'h1234, dma_o.data);
        chk("byte_addr", 32'h0003, dma_o.addr);
        chk("upper_dual", 32'h0, dma_o.upper);
        chk("long_addr_clr", 32'h0, long_addr);
        cfg_wr(8'h10);
        chk("send_on", 32'h1, send_enable);
        for (int c = 0; c < 4; c++)
        begin
            far_set(c[1:0], 1'b0, 4'h0);
            chk("loop_mode", c, loop_mode);
            chk("loop_active", c != 0, loop_active);
        end
        cfg_wr(8'h98);
        chk("loop_normal", 32'h0, loop_mode);
        chk("bit7_ignored", 32'h1, send_enable);
        ahb(1'b0, DCF_ADDR_STATUS, '0, rd);
        chk("status_final", 32'h0000_0208, rd);
        summarize();
    end

    initial
    begin
        #100000;
        err_total++;
        summarize();
    end
endmodule : dcf_data_config_tb

/* File: dcf_far_model.sv */
`timescale 1ns/10ps
module dcf_far_model (
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    input  wire logic [1:0]           lb_cmd,
    input  wire logic                 rx_cmd,
    input  wire logic [3:0]           lvl_cmd,
    input  wire dcf_pkg::dcf_dma_in_t dma_cmd,
    output      logic [1:0]           loopback_code,
    output      logic                 rx_active,
    output      logic [3:0]           fifo_level,
    output      dcf_pkg::dcf_dma_in_t dma_i
);
    import dcf_pkg::*;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            loopback_code <= DCF_LOOP_NORMAL;
            rx_active     <= 1'b0;
            fifo_level    <= 4'h0;
            dma_i         <= '0;
        end
        else
        begin
            loopback_code <= lb_cmd;
            rx_active     <= rx_cmd;
            // Fill level is meaningless outside reception
            fifo_level    <= rx_cmd ? lvl_cmd : ~fifo_level;
            dma_i         <= dma_cmd;
        end
    end
endmodule : dcf_far_model

/* File: dcf_lanes.sv */
`timescale 1ns/10ps
module dcf_lanes (
    input  wire logic            hclk,
    input  wire logic            hresetn,
    input  wire dcf_pkg::dcf_cfg_t    cfg,
    input  wire dcf_pkg::dcf_dma_in_t dma_i,
    output      dcf_pkg::dcf_dma_out_t dma_o
);
    import dcf_pkg::*;

    dcf_dma_out_t s_r;
    dcf_dma_out_t s_nxt;
    logic         swap;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    always_comb
    begin
        s_nxt = s_r;
        swap = cfg.word_transfer_select & cfg.byte_order_select;
        s_nxt.data = swap ? {dma_i.data[7:0], dma_i.data[15:8]} : dma_i.data;
        s_nxt.addr = {dma_i.addr[15:1], dma_i.addr[0] & ~cfg.word_transfer_select};
        s_nxt.upper = cfg.long_address_select ? dma_i.start_hi : 16'h0000;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign dma_o = s_r;

    a_word_lsb: assert property (cfg.word_transfer_select |=> !dma_o.addr[0])
        else $error("word mode address lsb not low");
    a_lane_swap: assert property (
        (cfg.word_transfer_select && cfg.byte_order_select)
        |=> dma_o.data == {$past(dma_i.data[7:0]), $past(dma_i.data[15:8])})
        else $error("byte lanes not swapped");
    a_swap_ignored: assert property (!cfg.word_transfer_select |=> dma_o.data == $past(dma_i.data))
        else $error("byte order applied in byte mode");
    a_upper_addr: assert property (
        (cfg.long_address_select |=> dma_o.upper == $past(dma_i.start_hi))
        and (!cfg.long_address_select |=> dma_o.upper == 16'h0000))
        else $error("upper address wrong for address mode");

endmodule : dcf_lanes

/* File: dcf_pkg.sv */
package dcf_pkg;

    // Register indices, byte address is four times the index
    localparam logic [31:0] DCF_IDX_DATA_CONFIG  = 32'h0000_000e;
    localparam logic [31:0] DCF_IDX_STATUS       = 32'h0000_0010;
    localparam logic [31:0] DCF_ADDR_DATA_CONFIG = DCF_IDX_DATA_CONFIG << 2;
    localparam logic [31:0] DCF_ADDR_STATUS      = DCF_IDX_STATUS << 2;

    // Configuration width in bits, power-up value has long addressing set
    localparam int          DCF_CFG_W   = 7;
    localparam logic [6:0]  DCF_CFG_RST = 7'h04;

    // Status word field positions
    localparam int DCF_ST_WORD   = 0;
    localparam int DCF_ST_SWAP   = 1;
    localparam int DCF_ST_LONG   = 2;
    localparam int DCF_ST_SEND   = 3;
    localparam int DCF_ST_LOOP   = 4;
    localparam int DCF_ST_LPACT  = 6;
    localparam int DCF_ST_THR    = 8;
    localparam int DCF_ST_REQ    = 12;

    // Loopback codes
    localparam logic [1:0] DCF_LOOP_NORMAL = 2'h0;

    // Receive thresholds, in words or bytes
    localparam logic [3:0] DCF_THR_W0 = 4'h1;
    localparam logic [3:0] DCF_THR_W1 = 4'h2;
    localparam logic [3:0] DCF_THR_W2 = 4'h4;
    localparam logic [3:0] DCF_THR_W3 = 4'h6;
    localparam logic [3:0] DCF_THR_B0 = 4'h2;
    localparam logic [3:0] DCF_THR_B1 = 4'h4;
    localparam logic [3:0] DCF_THR_B2 = 4'h8;
    localparam logic [3:0] DCF_THR_B3 = 4'hc;

    typedef enum logic [2:0] {
        DCF_PH_IDLE = 3'h1,
        DCF_PH_WR   = 3'h2,
        DCF_PH_RD   = 3'h4
    } dcf_phase_t;

    typedef struct packed {
        logic [1:0] fifo_threshold;
        logic       auto_init_remote;
        logic       loopback_select;
        logic       long_address_select;
        logic       byte_order_select;
        logic       word_transfer_select;
    } dcf_cfg_t;

    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic [31:0] hwdata;
        logic        hready;
    } dcf_ahb_in_t;

    typedef struct packed {
        logic [31:0] hrdata;
        logic        hreadyout;
        logic        hresp;
    } dcf_ahb_out_t;

    typedef struct packed {
        logic [15:0] start_hi;
        logic [15:0] addr;
        logic [15:0] data;
    } dcf_dma_in_t;

    typedef struct packed {
        logic [15:0] upper;
        logic [15:0] addr;
        logic [15:0] data;
    } dcf_dma_out_t;

    typedef struct packed {
        dcf_phase_t  phase;
        logic        hit_cfg;
        logic        hit_stat;
        logic        ready;
        logic [31:0] rdata;
        dcf_cfg_t    cfg;
        logic [1:0]  loop_mode;
        logic        loop_active;
        logic [3:0]  thr;
        logic        req;
    } dcf_state_t;

    function automatic logic [3:0] dcf_thr_count(input logic [1:0] code, input logic wide);
        logic [3:0] v;
        v = '0;
        unique case (code)
            2'h0: v = wide ? DCF_THR_W0 : DCF_THR_B0;
            2'h1: v = wide ? DCF_THR_W1 : DCF_THR_B1;
            2'h2: v = wide ? DCF_THR_W2 : DCF_THR_B2;
            2'h3: v = wide ? DCF_THR_W3 : DCF_THR_B3;
        endcase
        return v;
    endfunction : dcf_thr_count

endpackage : dcf_pkg
